// [hdl/pbfs_defs.svh]
`ifndef PBFS_DEFS_SVH
`define PBFS_DEFS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define PBFS_CTRL_ADDR    12'h000
`define PBFS_STATUS_ADDR  12'h004
`define PBFS_CTRL_RESET   16'h0000

// ****************************************************************
// Field positions in the control register
// ****************************************************************
`define PBFS_PB6_HI 13
`define PBFS_PB6_LO 12
`define PBFS_PB5_HI 11
`define PBFS_PB5_LO 10
`define PBFS_PB4_HI 9
`define PBFS_PB4_LO 8
`define PBFS_PB3_HI 7
`define PBFS_PB3_LO 6
`define PBFS_CTRL_MASK 16'h3FC0

// ****************************************************************
// Pin numbering within the group of four
// ****************************************************************
`define PBFS_PIN3 0
`define PBFS_PIN4 1
`define PBFS_PIN5 2
`define PBFS_PIN6 3

`endif

// [hdl/pbfs_pkg.sv]
package pbfs_pkg;

	typedef enum logic [1:0] {
		PBFS_FN_PORT,
		PBFS_FN_IRQ,
		PBFS_FN_ALT2,
		PBFS_FN_ALT3
	} pbfs_fn_type;

	// Per-pin pad signals for the four pins (index 0 is bit 3).
	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe_n;
	} pbfs_pad_out_type;

	// Bus-side signals that may be routed to the pins.
	typedef struct packed {
		logic address_line_18;
		logic bus_grant_ack;
		logic read_write_strobe;
		logic upper_column_strobe;
		logic lower_column_strobe;
	} pbfs_bus_sig_type;

	// Inputs that the pins may feed.
	typedef struct packed {
		logic [3:0] ext_interrupt_request;
		logic [2:0] output_enable_input;
	} pbfs_pin_in_type;

endpackage

// [hdl/pbfs_sync.sv]
`timescale 1ns/10ps
`default_nettype none

// Three-stage synchroniser; a change is accepted once stages two and three agree.
module pbfs_sync (
	input  wire logic       CORE_CLK,
	input  wire logic       RST,
	input  wire logic [3:0] async_in,
	output var  logic [3:0] sync_out
);
	logic [3:0] s1_q;
	logic [3:0] s2_q;
	logic [3:0] s3_q;

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			s1_q <= 4'h0;
			s2_q <= 4'h0;
			s3_q <= 4'h0;
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			sync_out <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					sync_out[i] <= s3_q[i];
				end
			end
		end
	end
endmodule

`default_nettype wire

// [hdl/pbfs_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "pbfs_defs.svh"

module pbfs_top (
	input  wire logic                       CORE_CLK,
	input  wire logic                       RST,
	input  wire logic                       PSEL,
	input  wire logic                       PENABLE,
	input  wire logic                       PWRITE,
	input  wire logic [11:0]                PADDR,
	input  wire logic [31:0]                PWDATA,
	output var  logic [31:0]                PRDATA,
	output var  logic                       PREADY,
	output var  logic                       PSLVERR,
	input  wire logic                       SINGLE_CHIP,
	input  wire logic [3:0]                 PORT_DATA_OUT,
	input  wire logic [3:0]                 PORT_DIR_OUT,
	input  wire pbfs_pkg::pbfs_bus_sig_type BUS_SIG,
	input  wire logic [3:0]                 PAD_IN,
	output var  pbfs_pkg::pbfs_pad_out_type PAD_OUT,
	output var  pbfs_pkg::pbfs_pin_in_type  PIN_IN,
	output var  logic [3:0]                 PORT_DATA_IN
);
	import pbfs_pkg::*;

	// ****************************************************************
	// Register file
	// ****************************************************************
	logic [15:0] ctrl_q;
	logic [3:0]  pad_sync;
	logic        single_chip_q;

	function automatic pbfs_fn_type field(input logic [15:0] r, input int lo);
		field = pbfs_fn_type'(r[lo +: 2]);
	endfunction

	wire access = PSEL && PENABLE;
	wire hit_ctrl = PADDR == `PBFS_CTRL_ADDR;
	wire hit_stat = PADDR == `PBFS_STATUS_ADDR;

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			ctrl_q <= `PBFS_CTRL_RESET;
		end else if (access && PWRITE && hit_ctrl) begin
			ctrl_q <= PWDATA[15:0] & `PBFS_CTRL_MASK;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			PRDATA  <= 32'h0000_0000;
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
		end else begin
			PREADY  <= PSEL && !PENABLE;
			PSLVERR <= PSEL && !PENABLE && !hit_ctrl && !hit_stat;
			if (PSEL && !PENABLE && !PWRITE && hit_ctrl) begin
				PRDATA <= {16'h0000, ctrl_q};
			end else if (PSEL && !PENABLE && !PWRITE && hit_stat) begin
				PRDATA <= {27'h0000000, single_chip_q, pad_sync};
			end else begin
				PRDATA <= 32'h0000_0000;
			end
		end
	end

	// ****************************************************************
	// Pin inputs
	// ****************************************************************
	logic [3:0] sc_sync;

	pbfs_sync u_sync (
		.CORE_CLK (CORE_CLK),
		.RST      (RST),
		.async_in (PAD_IN),
		.sync_out (pad_sync)
	);

	pbfs_sync u_mode_sync (
		.CORE_CLK (CORE_CLK),
		.RST      (RST),
		.async_in ({3'h0, SINGLE_CHIP}),
		.sync_out (sc_sync)
	);

	assign single_chip_q = sc_sync[0];

	// ****************************************************************
	// Function routing
	// ****************************************************************
	pbfs_fn_type f6;
	pbfs_fn_type f5;
	pbfs_fn_type f4;
	pbfs_fn_type f3;
	logic        use_p6;
	logic        use_p5;
	logic        use_p4;
	logic        use_p3;
	logic        drive_p6;
	logic        drive_p5;
	logic        drive_p4;
	logic        drive_p3;
	logic        alt_p6;
	logic        alt_p5;
	logic        alt_p4;
	logic        alt_p3;
	logic [3:0]  use_port;
	logic [3:0]  alt_out;
	logic [3:0]  alt_drive;

	assign f6 = field(ctrl_q, `PBFS_PB6_LO);
	assign f5 = field(ctrl_q, `PBFS_PB5_LO);
	assign f4 = field(ctrl_q, `PBFS_PB4_LO);
	assign f3 = field(ctrl_q, `PBFS_PB3_LO);

	// ****************************************************************
	// Pin 6: port, request 4, address line 18 or bus grant acknowledge
	// ****************************************************************
	always_comb begin
		use_p6   = 1'b0;
		drive_p6 = 1'b0;
		alt_p6   = 1'b0;
		case (f6)
			PBFS_FN_PORT: begin
				use_p6 = 1'b1;
			end
			PBFS_FN_IRQ: begin
				use_p6 = 1'b0;
			end
			PBFS_FN_ALT2: begin
				use_p6   = single_chip_q;
				drive_p6 = 1'b1;
				alt_p6   = BUS_SIG.address_line_18;
			end
			PBFS_FN_ALT3: begin
				use_p6   = single_chip_q;
				drive_p6 = 1'b1;
				alt_p6   = BUS_SIG.bus_grant_ack;
			end
			default: begin
				use_p6 = 1'b1;
			end
		endcase
	end

	// ****************************************************************
	// Pin 5: port, request 3, output enable input 3 or read/write strobe
	// ****************************************************************
	always_comb begin
		use_p5   = 1'b0;
		drive_p5 = 1'b0;
		alt_p5   = 1'b0;
		case (f5)
			PBFS_FN_PORT: begin
				use_p5 = 1'b1;
			end
			PBFS_FN_IRQ: begin
				use_p5 = 1'b0;
			end
			PBFS_FN_ALT2: begin
				use_p5 = 1'b0;
			end
			PBFS_FN_ALT3: begin
				drive_p5 = 1'b1;
				alt_p5   = BUS_SIG.read_write_strobe;
			end
			default: begin
				use_p5 = 1'b1;
			end
		endcase
	end

	// ****************************************************************
	// Pin 4: port, request 2, output enable input 2 or upper column strobe
	// ****************************************************************
	always_comb begin
		use_p4   = 1'b0;
		drive_p4 = 1'b0;
		alt_p4   = 1'b0;
		case (f4)
			PBFS_FN_PORT: begin
				use_p4 = 1'b1;
			end
			PBFS_FN_IRQ: begin
				use_p4 = 1'b0;
			end
			PBFS_FN_ALT2: begin
				use_p4 = 1'b0;
			end
			PBFS_FN_ALT3: begin
				use_p4   = single_chip_q;
				drive_p4 = 1'b1;
				alt_p4   = BUS_SIG.upper_column_strobe;
			end
			default: begin
				use_p4 = 1'b1;
			end
		endcase
	end

	// ****************************************************************
	// Pin 3: port, request 1, output enable input 1 or lower column strobe
	// ****************************************************************
	always_comb begin
		use_p3   = 1'b0;
		drive_p3 = 1'b0;
		alt_p3   = 1'b0;
		case (f3)
			PBFS_FN_PORT: begin
				use_p3 = 1'b1;
			end
			PBFS_FN_IRQ: begin
				use_p3 = 1'b0;
			end
			PBFS_FN_ALT2: begin
				use_p3 = 1'b0;
			end
			PBFS_FN_ALT3: begin
				use_p3   = single_chip_q;
				drive_p3 = 1'b1;
				alt_p3   = BUS_SIG.lower_column_strobe;
			end
			default: begin
				use_p3 = 1'b1;
			end
		endcase
	end

	// Index 0 is pin 3 and index 3 is pin 6, as in the pad structs.
	assign use_port  = {use_p6, use_p5, use_p4, use_p3};
	assign alt_drive = {drive_p6, drive_p5, drive_p4, drive_p3};
	assign alt_out   = {alt_p6, alt_p5, alt_p4, alt_p3};

	// Pad drivers and routed inputs are registered so every output leaves a flip-flop.
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			PAD_OUT      <= '{out: 4'h0, oe_n: 4'hF};
			PIN_IN       <= '{ext_interrupt_request: 4'h0, output_enable_input: 3'h0};
			PORT_DATA_IN <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (use_port[i]) begin
					PAD_OUT.out[i]  <= PORT_DATA_OUT[i];
					PAD_OUT.oe_n[i] <= !PORT_DIR_OUT[i];
				end else begin
					PAD_OUT.out[i]  <= alt_out[i];
					PAD_OUT.oe_n[i] <= !alt_drive[i];
				end
			end
			PORT_DATA_IN <= pad_sync & use_port;
			PIN_IN.ext_interrupt_request <= {f6 == PBFS_FN_IRQ, f5 == PBFS_FN_IRQ,
				f4 == PBFS_FN_IRQ, f3 == PBFS_FN_IRQ} & pad_sync;
			PIN_IN.output_enable_input <= {f5 == PBFS_FN_ALT2, f4 == PBFS_FN_ALT2,
				f3 == PBFS_FN_ALT2} & pad_sync[2:0];
		end
	end
endmodule

`default_nettype wire

// [test/pbfs_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module pbfs_chk (
	input wire logic                       CORE_CLK,
	input wire logic                       RST,
	input wire logic                       PENABLE,
	input wire logic                       PWRITE,
	input wire logic [11:0]                PADDR,
	input wire logic [31:0]                PWDATA,
	input wire logic                       SINGLE_CHIP,
	input wire logic [3:0]                 PORT_DATA_OUT,
	input wire logic [3:0]                 PORT_DIR_OUT,
	input wire pbfs_pkg::pbfs_bus_sig_type BUS_SIG,
	input wire pbfs_pkg::pbfs_pad_out_type PAD_OUT,
	input wire pbfs_pkg::pbfs_pin_in_type  PIN_IN
);
	import pbfs_pkg::*;
	logic [7:0] f_q;
	logic [3:0] sc_q;
	wire logic  lo = sc_q == 4'h0 && !SINGLE_CHIP;
	wire logic  hi = &sc_q && SINGLE_CHIP;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	always_ff @(posedge CORE_CLK) begin
		sc_q <= {sc_q[2:0], SINGLE_CHIP};
	end
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			f_q <= 8'h00;
		end else if (PENABLE && PWRITE && PADDR == 12'h000) begin
			f_q <= PWDATA[13:6];
		end
	end
	pads_idle_a: assert property ($fell(RST) |-> PAD_OUT.oe_n == 4'hF && PIN_IN == 7'h00)
		else $error("pads not idle");
	pin6_addr_a: assert property (
		f_q[7:6] == 2'h2 && lo |=> PAD_OUT.out[3] == $past(BUS_SIG.address_line_18) && !PAD_OUT.oe_n[3])
		else $error("pin6 addr");
	pin6_ack_a: assert property (
		f_q[7:6] == 2'h3 && lo |=> PAD_OUT.out[3] == $past(BUS_SIG.bus_grant_ack) && !PAD_OUT.oe_n[3])
		else $error("pin6 ack");
	pin6_port_a: assert property (f_q[7] && hi |=> PAD_OUT.oe_n[3] == !$past(PORT_DIR_OUT[3]))
		else $error("pin6 fallback");
	pin5_strobe_a: assert property (
		f_q[5:4] == 2'h3 |=> PAD_OUT.out[2] == $past(BUS_SIG.read_write_strobe) && !PAD_OUT.oe_n[2])
		else $error("pin5 strobe");
	pin4_cas_a: assert property (
		f_q[3:2] == 2'h3 && lo |=> PAD_OUT.out[1] == $past(BUS_SIG.upper_column_strobe) && !PAD_OUT.oe_n[1])
		else $error("pin4 strobe");
	pin3_port_a: assert property (f_q[1:0] == 2'h3 && hi |=> PAD_OUT.out[0] == $past(PORT_DATA_OUT[0]))
		else $error("pin3 fallback");
	pin3_input_a: assert property (f_q[1] != f_q[0] |=> PAD_OUT.oe_n[0])
		else $error("pin3 driven");
endmodule
bind pbfs_top pbfs_chk u_chk (.CORE_CLK, .RST, .PENABLE, .PWRITE, .PADDR, .PWDATA, .SINGLE_CHIP,
	.PORT_DATA_OUT, .PORT_DIR_OUT, .BUS_SIG, .PAD_OUT, .PIN_IN);
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
	import pbfs_pkg::*;
	logic             clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, sc = 1'b0;
	logic             prdy, perr, er;
	logic [11:0]      pa = 12'h000;
	logic [31:0]      pwd = 32'h0, prd, rd;
	logic [3:0]       pdo = 4'h0, pdir = 4'h0, pad = 4'h0, pdi;
	pbfs_bus_sig_type bus = 5'h00;
	pbfs_pad_out_type po;
	pbfs_pin_in_type  pin;
	int               err_count = 0, n_compared = 0;
	pbfs_top u_dut (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
		.PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .SINGLE_CHIP(sc), .PORT_DATA_OUT(pdo),
		.PORT_DIR_OUT(pdir), .BUS_SIG(bus), .PAD_IN(pad), .PAD_OUT(po), .PIN_IN(pin), .PORT_DATA_IN(pdi));
	always #50 clk = ~clk;
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (prdy !== 1'b1);
		rd = prd;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	function automatic logic [7:0] ep(input logic [7:0] f);
		logic [1:0] fn;
		logic [3:0] o, e, s3;
		s3 = {bus.bus_grant_ack, bus.read_write_strobe, bus.upper_column_strobe, bus.lower_column_strobe};
		for (int i = 0; i < 4; i++) begin
			fn = f[2*i +: 2];
			if (fn == 2'h0 || (sc && fn[1] && (i == 3 || (fn[0] && i < 2)))) begin
				o[i] = pdo[i];
				e[i] = ~pdir[i];
			end else if (fn == 2'h3 || (fn == 2'h2 && i == 3)) begin
				o[i] = fn[0] ? s3[i] : bus.address_line_18;
				e[i] = 1'b0;
			end else begin
				o[i] = 1'b0;
				e[i] = 1'b1;
			end
		end
		return {o & ~e, e};
	endfunction
	task automatic t_start;
		cmp(po.oe_n, 4'hF);
		apb(1'b0, 12'h000, 32'h0);
		cmp(rd, 32'h0);
		apb(1'b1, 12'h008, 32'hFFFF_FFFF);
		cmp(er, 1'b1);
	endtask
	task automatic t_modes(input logic s);
		logic [7:0] f, x;
		sc <= s;
		pad <= s ? 4'h5 : 4'hA;
		pdo <= s ? 4'h3 : 4'hC;
		pdir <= s ? 4'h9 : 4'h6;
		bus <= s ? 5'h0A : 5'h15;
		repeat (6) @(posedge clk);
		apb(1'b0, 12'h004, 32'h0);
		cmp(rd, {27'h0, s, pad});
		for (int k = 0; k < 4; k++) begin
			f = {4{k[1:0]}};
			apb(1'b1, 12'h000, {18'h3FFFF, f, 6'h3F});
			apb(1'b0, 12'h000, 32'h0);
			cmp(rd, {18'h0, f, 6'h00});
			repeat (6) @(posedge clk);
			x = ep(f);
			cmp(po.oe_n, x[3:0]);
			cmp(po.out & ~x[3:0], x[7:4]);
			cmp(pin.ext_interrupt_request, k == 1 ? pad : 4'h0);
			cmp(pin.output_enable_input, k == 2 ? pad[2:0] : 3'h0);
			cmp(pdi, k == 0 ? pad : (s && k == 3 ? pad & 4'hB : (s && k == 2 ? pad & 4'h8 : 4'h0)));
		end
	endtask
	task automatic tally_and_finish;
		if (err_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		#200000;
		err_count++;
		tally_and_finish;
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_start;
		t_modes(1'b0);
		t_modes(1'b1);
		tally_and_finish;
	end
endmodule
`default_nettype wire
